// *** core/pmd_pkg.sv ***
// constants shared by the page-mode dram controller and its refresh timer
// assumes a 25 mhz system clock; all figures below are turned into cycles here
package pmd_pkg;

    // system clock period
    localparam int unsigned CLK_PERIOD_NS   = 40;

    // power-up pause, least time, rounds up
    localparam int unsigned PWRUP_PAUSE_US  = 200;
    localparam int unsigned PWRUP_CYC       =
        (PWRUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // wake-up refresh cycles after power-up or after a missed refresh period
    localparam int unsigned WAKE_CYCLES     = 8;

    // refresh period and rows; per-row interval is a longest time, rounds down
    localparam int unsigned REF_PERIOD_MS   = 16;
    localparam int unsigned REF_ROWS        = 1024;
    localparam int unsigned REF_INTERVAL_CYC =
        (REF_PERIOD_MS * 1000000 / REF_ROWS) / CLK_PERIOD_NS;

    // backlog of owed refreshes that counts as a missed refresh period
    localparam int unsigned REF_PEND_MAX    = 8;

    // pin level after reset: all strobes and controls inactive
    localparam logic        PIN_IDLE        = 1'h1;

endpackage : pmd_pkg

// *** core/pmd_refresh_if.sv ***
// handshake between the refresh interval timer and the access sequencer
// assumes both ends run on the same clock
interface pmd_refresh_if;
    logic due;       // at least one refresh owed
    logic overrun;   // backlog full: refresh period missed
    logic taken;     // one-cycle pulse: a refresh cycle was issued

    // timer end
    modport timer (output due, output overrun, input taken);
    // sequencer end
    modport ctrl  (input due, input overrun, output taken);
endinterface : pmd_refresh_if

// *** core/pmd_refresh_timer.sv ***
// refresh interval timer: counts owed refresh cycles for the sequencer
// assumes taken pulses come from the same clock domain
module pmd_refresh_timer #(
    parameter int unsigned INTERVAL_CYC = pmd_pkg::REF_INTERVAL_CYC,
    parameter int unsigned PEND_MAX     = pmd_pkg::REF_PEND_MAX
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    // sequencer side
    pmd_refresh_if.timer      rif
);
    localparam int unsigned IW = $clog2(INTERVAL_CYC + 1);
    localparam int unsigned PW = $clog2(PEND_MAX + 1);

    // whole timer state
    typedef struct packed {
        logic [IW-1:0] ivl;      // cycles into current interval
        logic [PW-1:0] pend;     // owed refreshes
        logic          due;      // registered pend != 0
        logic          overrun;  // registered pend == max
    } pmd_tmr_s;

    pmd_tmr_s q;       // registered state
    pmd_tmr_s d;       // next state

    // interval count and owed-refresh bookkeeping
    always_comb begin
        logic tick;
        tick = (q.ivl == IW'(INTERVAL_CYC - 1));
        d = q;
        d.ivl = tick ? '0 : q.ivl + IW'(1);
        // a tick and a take in the same cycle cancel, so no owed cycle is lost
        if (tick && !rif.taken) begin
            if (q.pend != PW'(PEND_MAX)) begin
                d.pend = q.pend + PW'(1);
            end
        end else if (!tick && rif.taken && q.pend != '0) begin
            d.pend = q.pend - PW'(1);
        end
        d.due     = (d.pend != '0);
        d.overrun = (d.pend == PW'(PEND_MAX));
    end

    // register the state; frozen while ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '{default: '0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign rif.due     = q.due;
    assign rif.overrun = q.overrun;

endmodule : pmd_refresh_timer

// *** core/pmd_ctrl.sv ***
// host-side controller for a 1M x 16 fast-page-mode dram
// assumes clk at 25 mhz, a 2-flop synchroniser on the returned data lines,
// and a testbench that resolves the shared data wire from data_lines_oe
module pmd_ctrl #(
    parameter int unsigned ROW_W     = 10,
    parameter int unsigned COL_W     = 10,
    parameter int unsigned DATA_W    = 16,
    parameter int unsigned PWRUP_CYC = pmd_pkg::PWRUP_CYC
) (
    // clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    // user request
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire logic                   req_write,
    input  wire logic [ROW_W+COL_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0]      req_wdata,
    input  wire logic [1:0]             req_be,
    // user read answer
    output logic                        rsp_valid,
    output logic [DATA_W-1:0]           rsp_rdata,
    // status
    output logic                        init_done,
    // dram pins
    output logic                        row_strobe_n,
    output logic                        lower_col_strobe_n,
    output logic                        upper_col_strobe_n,
    output logic                        write_en_n,
    output logic                        out_gate_n,
    output logic [ROW_W-1:0]            mux_addr,
    output logic [DATA_W-1:0]           data_lines_o,
    output logic                        data_lines_oe,
    input  wire logic [DATA_W-1:0]      data_lines_i
);
    // counter widths; the pause counter follows its parameter
    localparam int unsigned PCW = $clog2(PWRUP_CYC + 1);
    localparam int unsigned WCW = $clog2(pmd_pkg::WAKE_CYCLES + 1);

    // sequencer states, one-hot
    // only early writes are issued, each access opening and closing its own
    // row: simpler and fixed in latency, at the cost of page-mode bandwidth
    typedef enum logic [9:0] {
        ST_PWR      = 10'h001,  // power-up pause
        ST_IDLE     = 10'h002,  // strobes high, waiting
        ST_ROW      = 10'h004,  // row strobe low, row address out
        ST_COL      = 10'h008,  // column strobes low
        ST_HOLD1    = 10'h010,  // read data crossing the synchroniser
        ST_HOLD2    = 10'h020,  // read data captured
        ST_CBR_CAS  = 10'h040,  // column strobes low ahead of row strobe
        ST_CBR_RAS  = 10'h080,  // row strobe falls with column low
        ST_CBR_HOLD = 10'h100,  // row strobe held low alone
        ST_PRE      = 10'h200   // precharge, everything high
    } pmd_state_e;

    // whole controller state
    typedef struct packed {
        pmd_state_e        st;         // sequencer state
        logic [PCW-1:0]    pwr_cnt;    // power-up pause counter
        logic [WCW-1:0]    wake_cnt;   // wake-up refreshes still to issue
        logic              init_done;  // wake-up complete
        logic              ras_n;      // row strobe pin
        logic              lcs_n;      // lower column strobe pin
        logic              ucs_n;      // upper column strobe pin
        logic              we_n;       // write enable pin
        logic              oe_n;       // output gate pin
        logic [ROW_W-1:0]  addr;       // multiplexed address pins
        logic [DATA_W-1:0] dout;       // write data pins
        logic              dout_oe;    // we drive the data lines
        logic [DATA_W-1:0] sync1;      // first synchroniser stage
        logic [DATA_W-1:0] sync2;      // second synchroniser stage
        logic [COL_W-1:0]  col;        // latched column address
        logic [1:0]        be;         // latched byte lanes
        logic              write;      // latched direction
        logic              req_ready;  // request may be taken
        logic              rsp_valid;  // read answer pulse
        logic [DATA_W-1:0] rsp_data;   // read answer data
        logic              taken;      // refresh issued pulse
    } pmd_ctl_s;

    // constant state after reset: every pin inactive, pause running
    localparam pmd_ctl_s RST = '{
        st:      ST_PWR,
        ras_n:   pmd_pkg::PIN_IDLE,
        lcs_n:   pmd_pkg::PIN_IDLE,
        ucs_n:   pmd_pkg::PIN_IDLE,
        we_n:    pmd_pkg::PIN_IDLE,
        oe_n:    pmd_pkg::PIN_IDLE,
        default: '0
    };

    pmd_ctl_s      q;      // registered state
    pmd_ctl_s      d;      // next state
    pmd_refresh_if rif (); // timer link

    // refresh interval timer
    pmd_refresh_timer #(
        .INTERVAL_CYC (pmd_pkg::REF_INTERVAL_CYC),
        .PEND_MAX     (pmd_pkg::REF_PEND_MAX)
    ) u_timer (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .rif  (rif)
    );

    // all strobes and controls back high; used at every cycle end
    // dropping the data drive with them keeps us off the device's outputs
    function automatic pmd_ctl_s release_pins(input pmd_ctl_s s);
        pmd_ctl_s r;
        r = s;
        r.ras_n   = 1'h1;
        r.lcs_n   = 1'h1;
        r.ucs_n   = 1'h1;
        r.we_n    = 1'h1;
        r.oe_n    = 1'h1;
        r.dout_oe = 1'h0;
        return r;
    endfunction : release_pins

    // sequencer next state and pin values
    always_comb begin
        d = q;
        d.rsp_valid = 1'h0;
        d.taken     = 1'h0;
        // first stage is read only by the second
        d.sync1 = data_lines_i;
        d.sync2 = q.sync1;
        case (q.st)
            ST_PWR: begin
                // pause, then owe the full set of wake-up refreshes
                if (q.pwr_cnt == PCW'(PWRUP_CYC - 1)) begin
                    d.st       = ST_IDLE;
                    d.wake_cnt = WCW'(pmd_pkg::WAKE_CYCLES);
                end else begin
                    d.pwr_cnt = q.pwr_cnt + PCW'(1);
                end
            end
            ST_IDLE: begin
                if (q.req_ready && req_valid) begin
                    // row strobe falls with the row address
                    d.st      = ST_ROW;
                    d.ras_n   = 1'h0;
                    d.addr    = req_addr[ROW_W+COL_W-1:COL_W];
                    d.col     = req_addr[COL_W-1:0];
                    d.be      = req_be;
                    d.write   = req_write;
                    // write enable goes low before any column strobe
                    d.we_n    = !req_write;
                    d.dout    = req_wdata;
                    d.dout_oe = req_write;
                    // output gate stays high during writes
                    d.oe_n    = 1'h1;
                end else if (q.wake_cnt != '0 || rif.due) begin
                    // refresh when no request is taken; column strobes low first
                    // refresh only starts from idle with every pin high, so a
                    // hidden refresh never arises and the outputs stay open
                    d.st    = ST_CBR_CAS;
                    d.lcs_n = 1'h0;
                    d.ucs_n = 1'h0;
                    // a full backlog means the period was missed: wake up again;
                    // tested in here because a full backlog always owes a refresh
                    if (rif.overrun && q.wake_cnt == '0) begin
                        d.wake_cnt = WCW'(pmd_pkg::WAKE_CYCLES);
                    end
                end
            end

            ST_ROW: begin
                // one clock after row strobe; later than 37 ns, so access
                // time is then set by the column strobe alone
                d.st    = ST_COL;
                d.addr  = ROW_W'(q.col);
                d.lcs_n = !q.be[0];
                d.ucs_n = !q.be[1];
                // read starts as both column strobe and output gate fall
                d.oe_n  = q.write;
            end

            ST_COL: begin
                if (q.write) begin
                    // strobes low one full clock: pulse and hold met; release
                    // from d so the synchroniser keeps moving
                    d    = release_pins(d);
                    d.st = ST_PRE;
                end else begin
                    // read: column strobe and output gate stay low
                    d.st = ST_HOLD1;
                end
            end

            ST_HOLD1: begin
                // pins hold while the sampled word moves to the second stage
                d.st = ST_HOLD2;
            end

            ST_HOLD2: begin
                // data has crossed both synchroniser stages
                d.rsp_data  = q.sync2;
                d.rsp_valid = 1'h1;
                // write enable was high up to this release
                d           = release_pins(d);
                d.st        = ST_PRE;
            end

            ST_CBR_CAS: begin
                // column strobes have led by a whole clock
                d.st    = ST_CBR_RAS;
                d.ras_n = 1'h0;
                d.taken = 1'h1;
                if (q.wake_cnt != '0) begin
                    d.wake_cnt = q.wake_cnt - WCW'(1);
                end
            end

            ST_CBR_RAS: begin
                // column strobes held a full clock past the row fall
                d.st    = ST_CBR_HOLD;
                d.lcs_n = 1'h1;
                d.ucs_n = 1'h1;
            end

            ST_CBR_HOLD: begin
                // row strobe low two clocks in all, then precharge
                d       = release_pins(d);
                d.st    = ST_PRE;
            end

            ST_PRE: begin
                // both strobes high before any new cycle clears the output;
                // every cycle closes its row here, so no page mode is used
                d.st = ST_IDLE;
            end

            default: begin
                // stray code: fall back to the reset state
                d = RST;
            end
        endcase
        // done once the pause and all wake-up refreshes are behind us
        // a fresh wake-up after a missed period takes it low again
        d.init_done = (q.st != ST_PWR) && (d.wake_cnt == '0) && (q.st != ST_IDLE
                      || q.init_done || q.wake_cnt == '0);
        // no new request from the cycle after a refresh becomes owed
        d.req_ready = (d.st == ST_IDLE) && (d.wake_cnt == '0) && !rif.due
                      && !rif.overrun;
    end

    // register the state; frozen while ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // one-cycle refresh pulse back to the timer
    assign rif.taken = q.taken;

    // outputs straight from flops
    // so every pin edge follows the clock edge with no decode glitch
    assign req_ready          = q.req_ready;
    assign rsp_valid          = q.rsp_valid;
    assign rsp_rdata          = q.rsp_data;
    assign init_done          = q.init_done;
    assign row_strobe_n       = q.ras_n;
    assign lower_col_strobe_n = q.lcs_n;
    assign upper_col_strobe_n = q.ucs_n;
    assign write_en_n         = q.we_n;
    assign out_gate_n         = q.oe_n;
    assign mux_addr           = q.addr;
    assign data_lines_o       = q.dout;
    assign data_lines_oe      = q.dout_oe;

endmodule : pmd_ctrl

// *** test/pmd_ctrl_chk.sv ***
// pin-timing checks for the page-mode dram controller
// assumes one clock domain; bound into every controller instance
module pmd_ctrl_chk #(
    parameter int unsigned DATA_W    = 16,
    parameter int unsigned PWRUP_CYC = pmd_pkg::PWRUP_CYC
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              ce,
    // user side
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              req_write,
    input wire logic              rsp_valid,
    input wire logic              init_done,
    // dram pins
    input wire logic              row_strobe_n,
    input wire logic              lower_col_strobe_n,
    input wire logic              upper_col_strobe_n,
    input wire logic              write_en_n,
    input wire logic              out_gate_n,
    input wire logic [DATA_W-1:0] data_lines_o,
    input wire logic              data_lines_oe
);
    int unsigned cyc_q;   // cycles since reset
    logic [3:0]  rows_q;  // row strobe falls since reset, saturating
    logic [9:0]  gap_q;   // cycles since last row strobe fall, saturating
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // row and gap counters saturate so a long idle spell cannot wrap them; cycle count does not
    always_ff @(posedge clk) begin
        if (srst) begin
            cyc_q  <= 0;
            rows_q <= 4'h0;
            gap_q  <= 10'h000;
        end else if (ce) begin
            cyc_q <= cyc_q + 1;
            if ($fell(row_strobe_n) && rows_q != 4'hF) rows_q <= rows_q + 4'h1;
            if ($fell(row_strobe_n)) gap_q <= 10'h000;
            else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
        end
    end
    a_pause_first_row: assert property (!row_strobe_n |-> cyc_q >= PWRUP_CYC)
        else $error("row strobe before the power-up pause");
    a_wake_before_ready: assert property (req_ready |-> rows_q >= 4'h8)
        else $error("ready before eight wake-up refreshes");
    a_refresh_gap_bound: assert property (init_done |-> gap_q < 10'h190)
        else $error("refresh interval overrun");
    a_refresh_strobe_order: assert property ($fell(row_strobe_n)
        && !($past(lower_col_strobe_n) && $past(upper_col_strobe_n))
        |-> !(lower_col_strobe_n && upper_col_strobe_n)
        ##1 (lower_col_strobe_n && upper_col_strobe_n && !row_strobe_n) ##1 row_strobe_n)
        else $error("refresh strobe sequence wrong");
    a_read_we_high: assert property (!out_gate_n |-> write_en_n && !data_lines_oe)
        else $error("write enable or drive during read");
    a_early_write_data: assert property (!write_en_n
        && ($fell(lower_col_strobe_n) || $fell(upper_col_strobe_n))
        |-> !$past(write_en_n) && data_lines_oe && $stable(data_lines_o))
        else $error("early write order or data hold broken");
    a_write_gate_high: assert property (!write_en_n |-> out_gate_n)
        else $error("output gate low during write");
    a_col_precharge: assert property ($rose(lower_col_strobe_n) |=> lower_col_strobe_n)
        else $error("column strobe precharge too short");
    a_row_min_low: assert property ($fell(row_strobe_n) |=> !row_strobe_n)
        else $error("row strobe pulse too short");
    a_row_precharge: assert property ($rose(row_strobe_n) |=> row_strobe_n)
        else $error("row strobe precharge too short");
    a_row_to_col: assert property (!row_strobe_n
        && ($fell(lower_col_strobe_n) || $fell(upper_col_strobe_n)) |-> !$past(row_strobe_n))
        else $error("column strobe too soon after row strobe");
    a_read_answer_time: assert property (req_valid && req_ready && !req_write
        |=> !rsp_valid [*4] ##1 rsp_valid)
        else $error("read answer not five cycles after take");
endmodule : pmd_ctrl_chk

bind pmd_ctrl pmd_ctrl_chk #(.DATA_W(DATA_W), .PWRUP_CYC(PWRUP_CYC)) pmd_ctrl_chk_i (
    .clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .rsp_valid(rsp_valid), .init_done(init_done),
    .row_strobe_n(row_strobe_n), .lower_col_strobe_n(lower_col_strobe_n),
    .upper_col_strobe_n(upper_col_strobe_n), .write_en_n(write_en_n),
    .out_gate_n(out_gate_n), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));

// *** test/pmd_dram_model.sv ***
// behavioural 1M x 16 fast-page-mode dram on the controller's pins
// assumes zero access delay; the bench merges its output with the controller's drive
module pmd_dram_model (
    // strobes and controls
    input  wire logic        row_strobe_n,
    input  wire logic        lower_col_strobe_n,
    input  wire logic        upper_col_strobe_n,
    input  wire logic        write_en_n,
    input  wire logic        out_gate_n,
    // address and data
    input  wire logic [9:0]  mux_addr,
    input  wire logic [15:0] data_lines,
    output logic      [15:0] dev_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [19:0]];  // sparse cell array
    logic [9:0]  row_q;               // row taken at row strobe fall
    logic        refr_q = 1'b0;       // column strobe was low at row fall
    logic [15:0] rd_q = 16'h0000;     // last word fetched, per lane
    wire  [1:0]  cs_n = {upper_col_strobe_n, lower_col_strobe_n};
    // row fall; 1 ns later since pins move together on the clock edge
    always @(negedge row_strobe_n) begin
        #1;
        refr_q = !(lower_col_strobe_n && upper_col_strobe_n);
        if (!refr_q) row_q = mux_addr;
    end
    for (genvar b = 0; b < 2; b++) begin : g_lane
        // column fall: store the lane on a write, else fetch it
        always @(negedge cs_n[b]) begin
            logic [15:0] w;
            #1;
            w = mem.exists({row_q, mux_addr}) ? mem[{row_q, mux_addr}] : 16'h0000;
            if (!row_strobe_n && !refr_q && !write_en_n) begin
                w[b*8+:8] = data_lines[b*8+:8];
                mem[{row_q, mux_addr}] = w;
            end else if (!row_strobe_n && !refr_q) begin
                rd_q[b*8+:8] = w[b*8+:8];
            end
        end
        // released lane shows the inverse of its last word, never a stale match
        assign dev_dq[b*8+:8] = (!row_strobe_n && !refr_q && !cs_n[b] && write_en_n
            && !out_gate_n) ? rd_q[b*8+:8] : ~rd_q[b*8+:8];
    end
endmodule : pmd_dram_model

// *** test/tb.sv ***
// self-checking bench for the page-mode dram controller
// assumes the dram model answers at once on the shared data wire
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // one transfer: write data, or the word a read should return
    typedef struct {logic wr; logic [19:0] addr; logic [15:0] data; logic [1:0] be;} pmd_xfer_s;
    logic        clk, srst, ce, req_valid, req_ready, req_write, rsp_valid, init_done;
    logic [19:0] req_addr;
    logic [15:0] req_wdata, rsp_rdata, data_lines_o, data_lines_i, dev_dq;
    logic [1:0]  req_be;
    logic        row_strobe_n, lower_col_strobe_n, upper_col_strobe_n, write_en_n;
    logic        out_gate_n, data_lines_oe;
    logic [9:0]  mux_addr;
    int          bad_count = 0, compares = 0, refresh_cnt = 0;
    pmd_xfer_s   rows [10];
    logic [4:0]  pin_snap;  // strobe and control levels when the clock enable drops
    wire  [4:0]  pin_now = {row_strobe_n, lower_col_strobe_n, upper_col_strobe_n,
                            write_en_n, out_gate_n};
    // controller drive wins, else the device's lanes
    assign data_lines_i = data_lines_oe ? data_lines_o : dev_dq;
    pmd_ctrl #(.PWRUP_CYC(10)) pmd_ctrl_i (
        .clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
        .row_strobe_n(row_strobe_n), .lower_col_strobe_n(lower_col_strobe_n),
        .upper_col_strobe_n(upper_col_strobe_n), .write_en_n(write_en_n),
        .out_gate_n(out_gate_n), .mux_addr(mux_addr), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
    pmd_dram_model pmd_dram_model_i (
        .row_strobe_n(row_strobe_n), .lower_col_strobe_n(lower_col_strobe_n),
        .upper_col_strobe_n(upper_col_strobe_n), .write_en_n(write_en_n),
        .out_gate_n(out_gate_n), .mux_addr(mux_addr), .data_lines(data_lines_i),
        .dev_dq(dev_dq));
    // 25 mhz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // count refreshes: column strobe already low when the row strobe falls
    always @(negedge row_strobe_n) if (!lower_col_strobe_n || !upper_col_strobe_n) refresh_cnt++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    // offer one request; valid stays up so the next call may follow at once
    task automatic access(input pmd_xfer_s r);
        int k;
        logic [15:0] m;
        m = {{8{r.be[1]}}, {8{r.be[0]}}};
        req_write = r.wr;
        req_addr = r.addr;
        req_wdata = r.data;
        req_be = r.be;
        req_valid = 1'b1;
        for (k = 0; k < 500 && req_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        if (!r.wr) begin
            repeat (4) @(negedge clk);
            check(16'(rsp_valid), 16'h0001);
            check(rsp_rdata & m, r.data & m);
        end
    endtask : access
    // reset, pin levels while held, then the wake-up sequence
    task automatic do_reset();
        int k;
        logic [15:0] pins;
        srst = 1'b1;
        repeat (5) @(negedge clk);
        pins = {row_strobe_n, lower_col_strobe_n, upper_col_strobe_n, write_en_n, out_gate_n,
                data_lines_oe, req_ready, init_done};
        check(pins, 16'h00F8);
        srst = 1'b0;
        refresh_cnt = 0;
        for (k = 0; k < 200 && init_done !== 1'b1; k++) @(negedge clk);
        check(16'(k >= 10), 16'h0001);
        check(16'(refresh_cnt), 16'h0008);
    endtask : do_reset
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        {req_valid, req_write, req_addr, req_wdata, req_be} = 40'h00_0000_0000;
        // back-to-back word, byte and empty-lane traffic, corner addresses
        rows = '{'{1'h1, 20'h0_0001, 16'hA5C3, 2'h3}, '{1'h1, 20'hF_FFFF, 16'h1234, 2'h3},
                 '{1'h1, 20'hF_FFFF, 16'hBEEF, 2'h1}, '{1'h0, 20'h0_0001, 16'hA5C3, 2'h3},
                 '{1'h0, 20'hF_FFFF, 16'h12EF, 2'h3}, '{1'h1, 20'h0_0001, 16'h7700, 2'h2},
                 '{1'h0, 20'h0_0001, 16'h7700, 2'h2}, '{1'h0, 20'h0_0001, 16'h00C3, 2'h1},
                 '{1'h1, 20'h0_0001, 16'hFFFF, 2'h0}, '{1'h0, 20'h0_0001, 16'h77C3, 2'h3}};
        do_reset();
        foreach (rows[i]) access(rows[i]);
        req_valid = 1'b0;
        // idle: only the refresh timer strobes the rows, one per 390 cycles
        refresh_cnt = 0;
        repeat (1200) @(negedge clk);
        check(16'(refresh_cnt >= 3 && refresh_cnt <= 4), 16'h0001);
        // clock enable low: pins and refresh timer stand still, no refresh issued
        ce = 1'b0;
        pin_snap = pin_now;
        refresh_cnt = 0;
        repeat (800) @(negedge clk);
        check(16'(refresh_cnt), 16'h0000);
        check(16'(pin_now), 16'(pin_snap));
        ce = 1'b1;
        // reset in mid-run, then the stored word must still read back
        do_reset();
        access(rows[9]);
        complete_run();
    end
endmodule : tb
